// File: flsw_pkg.sv
// flsw_pkg: constants, opcodes, status layout and types for the flash
// status-write and read command interpreter; used by every flsw module.
package flsw_pkg;

	// clock and self-timed status write duration
	localparam int CLK_PERIOD_NS = 10;
	localparam longint NV_STATUS_WRITE_NS = 5000000;
	localparam int NV_WRITE_CYCLES = int'((NV_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WSR1 = 8'h01;
	localparam logic [7:0] OP_WSR2 = 8'h31;
	localparam logic [7:0] OP_WSR3 = 8'h11;
	localparam logic [7:0] OP_RSR1 = 8'h05;
	localparam logic [7:0] OP_RSR2 = 8'h35;
	localparam logic [7:0] OP_RSR3 = 8'h15;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DUAL = 8'h3b;
	localparam logic [7:0] OP_SETP = 8'hc0;

	// status registers, index 0 = register 1
	typedef logic [2:0][7:0] flsw_sr_t;
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_QE_BIT = 1;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam flsw_sr_t WR_MASK = {8'he0, 8'h7b, 8'hfc};
	localparam flsw_sr_t OTP_MASK = {8'h00, 8'h38, 8'h00};
	localparam flsw_sr_t QE_MASK = {8'h00, 8'h02, 8'h00};

	// read parameters
	localparam int DUMMY_FIELD_LSB = 4;
	localparam logic [1:0] DUMMY_FIELD_RESET = 2'h2;
	localparam logic [3:0] DUMMY_STD = 4'h8;
	localparam logic [3:0] DUMMY_4 = 4'h4;
	localparam logic [3:0] DUMMY_6 = 4'h6;

	// phase lengths in bits, lanes
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] BYTE_BITS = 6'h08;
	localparam int LANE_DI = 0;
	localparam int LANE_DO = 1;
	localparam logic [5:0] PIN_IDLE = 6'h10;

	typedef struct packed {
		logic sck;
		logic cs_n;
		logic [3:0] lanes;
	} flsw_pins_t;

	typedef struct packed {
		logic nv;
		logic [2:0] sel;
		flsw_sr_t data;
	} flsw_wsr_t;

	typedef enum logic [2:0] {
		ST_CMD = 3'h0,
		ST_ADDR = 3'h1,
		ST_DUMMY = 3'h3,
		ST_DATA = 3'h2,
		ST_WDATA = 3'h6,
		ST_WAIT = 3'h7,
		ST_IGNORE = 3'h5
	} flsw_state_t;

	typedef enum logic [2:0] {
		OW_1 = 3'h1,
		OW_2 = 3'h2,
		OW_4 = 3'h4
	} flsw_width_t;

	// last input clock index of a phase
	function automatic logic [5:0] clk_last(input logic [5:0] bits, input logic quad);
		clk_last = quad ? ((bits >> 2) - 6'h01) : (bits - 6'h01);
	endfunction : clk_last

	// last output clock index of a byte
	function automatic logic [2:0] out_last(input flsw_width_t w);
		case (w)
			OW_4: out_last = 3'h1;
			OW_2: out_last = 3'h3;
			default: out_last = 3'h7;
		endcase
	endfunction : out_last

	function automatic logic [3:0] dummy_clocks(input logic [1:0] field);
		case (field)
			2'h0: dummy_clocks = DUMMY_4;
			2'h1: dummy_clocks = DUMMY_6;
			default: dummy_clocks = DUMMY_STD;
		endcase
	endfunction : dummy_clocks

endpackage : flsw_pkg

// File: flsw_pin_sync.sv
// flsw_pin_sync: two-flop synchronisers for the serial link pins.
// assumes raw pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module flsw_pin_sync import flsw_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins
	input wire flsw_pins_t pins_raw,
	output flsw_pins_t pins_sync
);
	logic [5:0] meta_q;
	logic [5:0] sync_q;

	for (genvar i = 0; i < 6; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				meta_q[i] <= PIN_IDLE[i];
				sync_q[i] <= PIN_IDLE[i];
			end else begin
				meta_q[i] <= pins_raw[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	assign pins_sync = sync_q;
endmodule : flsw_pin_sync
`default_nettype wire

// File: flsw_status_store.sv
// flsw_status_store: non-volatile and active copies of the three status
// registers with write masks and one-time lock bits.
// assumes one write strobe per accepted status write.
`timescale 1ns/100ps
`default_nettype none
module flsw_status_store import flsw_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// write request
	input wire logic wr_stb,
	input wire flsw_wsr_t wr_req,
	input wire logic quad_mode,
	// active values
	output flsw_sr_t sr_active
);
	flsw_sr_t nv_q;
	flsw_sr_t act_q;

	for (genvar i = 0; i < 3; i++) begin : g_reg
		logic [7:0] m;
		logic [7:0] nv_new;
		logic [7:0] vol_new;
		assign m = WR_MASK[i] & ~(QE_MASK[i] & {8{quad_mode}});
		assign nv_new = (nv_q[i] & ~m) | (wr_req.data[i] & m) | (nv_q[i] & OTP_MASK[i]);
		assign vol_new = (act_q[i] & ~(m & ~OTP_MASK[i])) | (wr_req.data[i] & m & ~OTP_MASK[i]);

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				nv_q[i] <= SR_RESET;
				act_q[i] <= SR_RESET;
			end else if (soft_reset) begin
				act_q[i] <= nv_q[i];
			end else if (wr_stb && wr_req.sel[i]) begin
				if (wr_req.nv) begin
					nv_q[i] <= nv_new;
					act_q[i] <= nv_new;
				end else begin
					act_q[i] <= vol_new;
				end
			end
		end
	end

	assign sr_active = act_q;
endmodule : flsw_status_store
`default_nettype wire

// File: flsw_cmd_core.sv
// flsw_cmd_core: serial flash command interpreter for status writes and
// single, fast and dual-output reads; link pins are sampled by clk.
// assumes mem_rdata follows mem_addr within three clk cycles.
`timescale 1ns/100ps
`default_nettype none
module flsw_cmd_core import flsw_pkg::*; #(
	parameter int NV_WRITE_CYC = NV_WRITE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// serial link
	input wire logic sck_pin,
	input wire logic cs_n_pin,
	input wire logic [3:0] lane_in,
	output logic [3:0] lane_out,
	output logic [3:0] lane_oe_n,
	// device mode and state
	input wire logic four_wire_command_mode,
	input wire logic array_busy,
	// memory array
	output logic [23:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	// status
	output logic busy,
	output logic write_latch_flag,
	output logic four_lane_enable,
	output flsw_sr_t status_regs
);
	flsw_pins_t pins_raw;
	flsw_pins_t pins_s;
	logic sck_prev_q;
	logic cs_prev_q;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic quad;

	flsw_state_t state_q;
	logic [7:0] op_q;
	logic [23:0] addr_q;
	logic [3:0] dummy_q;
	flsw_width_t out_w_q;
	logic rd_stat_q;
	logic [1:0] sr_sel_q;
	logic [5:0] in_cnt_q;
	logic [23:0] in_sh_q;
	logic [1:0] nbytes_q;
	logic [1:0][7:0] wb_q;

	logic [23:0] in_shift;
	logic [5:0] phase_last;
	logic in_last;
	logic [7:0] op_c;

	logic wel_q;
	logic vol_en_q;
	logic [23:0] nv_cnt_q;
	flsw_wsr_t pend_q;
	logic wr_stb_q;
	flsw_wsr_t wr_req_q;
	logic [1:0] dummy_field_q;

	logic [2:0] out_cnt_q;
	logic [7:0] out_sh_q;
	logic [3:0] lane_out_q;
	logic [3:0] lane_oe_n_q;
	logic load_c;
	logic [7:0] cur_c;
	flsw_sr_t sr_active;
	flsw_sr_t sr_read;
	logic wsr_busy;
	logic wsr_op;
	logic wsr_end;
	flsw_wsr_t wsr_c;

	assign pins_raw = '{sck: sck_pin, cs_n: cs_n_pin, lanes: lane_in};

	flsw_pin_sync u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pins_raw(pins_raw),
		.pins_sync(pins_s)
	);

	flsw_status_store u_store (
		.clk(clk),
		.reset_n(reset_n),
		.soft_reset(soft_reset),
		.wr_stb(wr_stb_q),
		.wr_req(wr_req_q),
		.quad_mode(four_wire_command_mode),
		.sr_active(sr_active)
	);

	// link edges
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= pins_s.sck;
			cs_prev_q <= pins_s.cs_n;
		end
	end

	assign sck_rise = pins_s.sck & ~sck_prev_q & ~pins_s.cs_n;
	assign sck_fall = ~pins_s.sck & sck_prev_q & ~pins_s.cs_n;
	assign cs_rise = pins_s.cs_n & ~cs_prev_q;
	assign quad = four_wire_command_mode;

	// input shifting, one bit or one nibble per clock
	assign in_shift = quad ? {in_sh_q[19:0], pins_s.lanes} : {in_sh_q[22:0], pins_s.lanes[LANE_DI]};
	assign op_c = in_shift[7:0];
	assign wsr_busy = (nv_cnt_q != 24'h000000);
	assign busy = wsr_busy | array_busy;
	assign wsr_op = (op_q == OP_WSR1) || (op_q == OP_WSR2) || (op_q == OP_WSR3);

	always_comb begin
		case (state_q)
			ST_ADDR: phase_last = clk_last(ADDR_BITS, quad);
			ST_DUMMY: phase_last = {2'h0, dummy_q - 4'h1};
			ST_WDATA: phase_last = clk_last(BYTE_BITS, quad);
			default: phase_last = clk_last(CMD_BITS, quad);
		endcase
	end

	assign in_last = (in_cnt_q == phase_last);

	// command sequencer
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_CMD;
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			dummy_q <= DUMMY_STD;
			out_w_q <= OW_1;
			rd_stat_q <= 1'b0;
			sr_sel_q <= 2'h0;
			in_cnt_q <= 6'h00;
			in_sh_q <= 24'h000000;
			nbytes_q <= 2'h0;
			wb_q <= '0;
		end else if (pins_s.cs_n) begin
			state_q <= ST_CMD;
			in_cnt_q <= 6'h00;
			nbytes_q <= 2'h0;
		end else if (sck_rise) begin
			in_sh_q <= in_shift;
			in_cnt_q <= in_last ? 6'h00 : in_cnt_q + 6'h01;
			case (state_q)
				ST_CMD: begin
					if (in_last) begin
						op_q <= op_c;
						out_w_q <= quad ? OW_4 : OW_1;
						rd_stat_q <= 1'b0;
						dummy_q <= DUMMY_STD;
						if (op_c == OP_RSR1 || op_c == OP_RSR2 || op_c == OP_RSR3) begin
							state_q <= ST_DATA;
							rd_stat_q <= 1'b1;
							sr_sel_q <= (op_c == OP_RSR1) ? 2'h0 : ((op_c == OP_RSR2) ? 2'h1 : 2'h2);
						end else if (busy) begin
							state_q <= ST_IGNORE;
						end else if (op_c == OP_READ && !quad) begin
							state_q <= ST_ADDR;
							dummy_q <= 4'h0;
						end else if (op_c == OP_FAST) begin
							state_q <= ST_ADDR;
							dummy_q <= quad ? dummy_clocks(dummy_field_q) : DUMMY_STD;
						end else if (op_c == OP_DUAL && !quad) begin
							state_q <= ST_ADDR;
							out_w_q <= OW_2;
						end else if ((op_c == OP_WSR1 || op_c == OP_WSR2 || op_c == OP_WSR3) && (wel_q || vol_en_q)) begin
							state_q <= ST_WDATA;
						end else if (op_c == OP_SETP) begin
							state_q <= ST_WDATA;
						end else if (op_c == OP_WREN || op_c == OP_WRDI || op_c == OP_VWREN) begin
							state_q <= ST_WAIT;
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_ADDR: begin
					if (in_last) begin
						addr_q <= in_shift;
						state_q <= (dummy_q == 4'h0) ? ST_DATA : ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					if (in_last) begin
						state_q <= ST_DATA;
					end
				end
				ST_WDATA: begin
					if (in_last) begin
						if (nbytes_q != 2'h2) begin
							wb_q[nbytes_q[0]] <= op_c;
							nbytes_q <= nbytes_q + 2'h1;
						end
					end
				end
				ST_DATA, ST_WAIT, ST_IGNORE: begin
					in_cnt_q <= 6'h00;
				end
				default: state_q <= ST_IGNORE;
			endcase
		end else if (load_c && !rd_stat_q) begin
			addr_q <= addr_q + 24'h000001;
		end
	end

	// read parameter field
	always_ff @(posedge clk) begin
		if (!reset_n || soft_reset) begin
			dummy_field_q <= DUMMY_FIELD_RESET;
		end else if (sck_rise && state_q == ST_WDATA && op_q == OP_SETP && in_last && nbytes_q == 2'h0) begin
			dummy_field_q <= op_c[DUMMY_FIELD_LSB +: 2];
		end
	end

	// status write request built at chip select rise
	always_comb begin
		wsr_c = '0;
		wsr_c.nv = wel_q;
		case (op_q)
			OP_WSR1: begin
				wsr_c.sel = (nbytes_q == 2'h2) ? 3'h3 : 3'h1;
				wsr_c.data[0] = wb_q[0];
				wsr_c.data[1] = wb_q[1];
			end
			OP_WSR2: begin
				wsr_c.sel = 3'h2;
				wsr_c.data[1] = wb_q[0];
			end
			default: begin
				wsr_c.sel = 3'h4;
				wsr_c.data[2] = wb_q[0];
			end
		endcase
	end

	assign wsr_end = cs_rise && state_q == ST_WDATA && wsr_op && in_cnt_q == 6'h00 && nbytes_q != 2'h0;

	// write latch, volatile enable and self-timed cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wel_q <= 1'b0;
			vol_en_q <= 1'b0;
			nv_cnt_q <= 24'h000000;
			pend_q <= '0;
			wr_stb_q <= 1'b0;
			wr_req_q <= '0;
		end else begin
			wr_stb_q <= 1'b0;
			if (cs_rise) begin
				vol_en_q <= (state_q == ST_WAIT && op_q == OP_VWREN);
			end
			if (wsr_busy) begin
				nv_cnt_q <= nv_cnt_q - 24'h000001;
				if (nv_cnt_q == 24'h000001) begin
					wr_stb_q <= 1'b1;
					wr_req_q <= pend_q;
					wel_q <= 1'b0;
				end
			end
			if (wsr_end && wel_q) begin
				nv_cnt_q <= 24'(NV_WRITE_CYC);
				pend_q <= wsr_c;
			end else if (wsr_end && vol_en_q) begin
				wr_stb_q <= 1'b1;
				wr_req_q <= wsr_c;
			end
			if (soft_reset) begin
				wel_q <= 1'b0;
				vol_en_q <= 1'b0;
			end else if (cs_rise && state_q == ST_WAIT && op_q == OP_WRDI) begin
				wel_q <= 1'b0;
			end else if (cs_rise && state_q == ST_WAIT && op_q == OP_WREN) begin
				wel_q <= 1'b1;
			end
		end
	end

	// data output on falling link clock edges
	always_comb begin
		sr_read = sr_active;
		sr_read[0][SR_BUSY_BIT] = busy;
		sr_read[0][SR_WEL_BIT] = wel_q;
	end

	assign load_c = sck_fall && state_q == ST_DATA && out_cnt_q == 3'h0;
	assign cur_c = (out_cnt_q != 3'h0) ? out_sh_q : (rd_stat_q ? sr_read[sr_sel_q] : mem_rdata);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_cnt_q <= 3'h0;
			out_sh_q <= 8'h00;
			lane_out_q <= 4'h0;
			lane_oe_n_q <= 4'hf;
		end else if (pins_s.cs_n || state_q != ST_DATA) begin
			out_cnt_q <= 3'h0;
			lane_oe_n_q <= 4'hf;
		end else if (sck_fall) begin
			out_sh_q <= cur_c << out_w_q;
			out_cnt_q <= (out_cnt_q == out_last(out_w_q)) ? 3'h0 : out_cnt_q + 3'h1;
			case (out_w_q)
				OW_4: begin
					lane_out_q <= cur_c[7:4];
					lane_oe_n_q <= 4'h0;
				end
				OW_2: begin
					lane_out_q <= {2'h0, cur_c[7], cur_c[6]};
					lane_oe_n_q <= 4'hc;
				end
				default: begin
					lane_out_q <= {2'h0, cur_c[7], 1'b0};
					lane_oe_n_q <= ~(4'h1 << LANE_DO);
				end
			endcase
		end
	end

	assign lane_out = lane_out_q;
	assign lane_oe_n = lane_oe_n_q;
	assign mem_addr = addr_q;
	assign write_latch_flag = wel_q;
	assign four_lane_enable = sr_active[1][SR_QE_BIT];
	assign status_regs = sr_read;
endmodule : flsw_cmd_core
`default_nettype wire

// File: flsw_cmd_core_props.sv
// flsw_cmd_core_props: port-level assertions for flsw_cmd_core.
// assumes binding onto flsw_cmd_core, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module flsw_cmd_core_props import flsw_pkg::*; #(
	parameter int NV_WRITE_CYC = NV_WRITE_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// link
	input wire logic cs_n_pin,
	input wire logic [3:0] lane_oe_n,
	// mode and memory
	input wire logic four_wire_command_mode,
	input wire logic array_busy,
	input wire logic [23:0] mem_addr,
	// status
	input wire logic busy,
	input wire logic write_latch_flag,
	input wire logic four_lane_enable,
	input wire flsw_sr_t status_regs
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	int busy_len_q;
	// length of a busy spell not caused by the array
	always_ff @(posedge clk) begin
		if (!reset_n || !busy || array_busy) begin
			busy_len_q <= 0;
		end else begin
			busy_len_q <= busy_len_q + 1;
		end
	end
	sequence cs_idle;
		cs_n_pin [*6];
	endsequence
	sequence wr_done;
		$fell(busy) && !array_busy && !$past(array_busy);
	endsequence
	a_reset_state: assert property (disable iff (1'b0) !reset_n |=>
		!write_latch_flag && lane_oe_n == 4'hf && mem_addr == 24'h0 && status_regs == 24'h0)
		else $error("state not cleared by reset");
	a_busy_span: assert property (wr_done |-> busy_len_q >= NV_WRITE_CYC - 1 && busy_len_q <= NV_WRITE_CYC + 1)
		else $error("write cycle length wrong");
	a_latch_clear: assert property (wr_done |-> ##[0:1] !write_latch_flag)
		else $error("latch not cleared after write");
	a_qe_frozen: assert property (four_wire_command_mode && !soft_reset |=> $stable(four_lane_enable))
		else $error("four lane enable changed in four wire mode");
	a_qe_mirror: assert property (four_lane_enable == status_regs[1][SR_QE_BIT])
		else $error("four lane enable differs from status");
	a_lock_sticky: assert property ((~status_regs[1] & $past(status_regs[1]) & OTP_MASK[1]) == 8'h00)
		else $error("lock bit cleared");
	a_rdonly_bits: assert property (((status_regs[1] & ~WR_MASK[1]) | (status_regs[2] & ~WR_MASK[2])) == 8'h00)
		else $error("read only status bit set");
	a_addr_step: assert property (!lane_oe_n[1] && $past(lane_oe_n[1]) == 1'b0 && $changed(mem_addr)
		|-> mem_addr == $past(mem_addr) + 24'h1)
		else $error("read address did not step by one");
	a_oe_idle: assert property (cs_idle |-> lane_oe_n == 4'hf)
		else $error("lanes driven while deselected");
	a_upper_lanes: assert property (!four_wire_command_mode |-> lane_oe_n[3:2] == 2'h3)
		else $error("upper lanes driven in single mode");
	a_busy_array: assert property (array_busy |-> busy)
		else $error("busy low while array busy");
endmodule : flsw_cmd_core_props
`default_nettype wire

// File: flsw_host.sv
// flsw_host: host side of the serial link, driven from bench tasks.
// assumes lanes is the resolved wire level of all four lanes.
`timescale 1ns/100ps
`default_nettype none
module flsw_host import flsw_pkg::*; (
	// clock
	input wire logic clk,
	// link
	input wire logic [3:0] lanes,
	output logic sck,
	output logic cs_n,
	output logic [3:0] lane_h
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		lane_h = 4'h0;
	end
	// one 80 ns link clock: drive in low phase, sample mid high phase
	task automatic cyc(input logic [3:0] v, output logic [3:0] o);
		lane_h <= v;
		repeat (4) @(posedge clk);
		sck <= 1'b1;
		repeat (2) @(posedge clk);
		o = lanes;
		repeat (2) @(posedge clk);
		sck <= 1'b0;
	endtask : cyc
	// unused lanes toggle so a stale level never looks valid
	task automatic bits(input logic [7:0] b, input int w, output logic [7:0] r);
		logic [3:0] o;
		for (int i = 0; i < 8 / w; i++) begin
			cyc(w == 4 ? b[7 - 4 * i -: 4] : {~lane_h[3:1], b[7 - i]}, o);
			r = w == 4 ? {r[3:0], o} : w == 2 ? {r[5:0], o[1:0]} : {r[6:0], o[1]};
		end
	endtask : bits
	task automatic frame_on;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : frame_on
	task automatic frame_off;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : frame_off
endmodule : flsw_host
`default_nettype wire

// File: flsw_cmd_core_bench.sv
// flsw_cmd_core_bench: command sequences through the host model.
// assumes memory data is address low byte xor 5a.
`timescale 1ns/100ps
`default_nettype none
module flsw_cmd_core_bench import flsw_pkg::*;;
	localparam int NVC = 200;
	logic clk, reset_n, soft_reset, fw, array_busy, sck, cs_n, busy, write_latch_flag, four_lane_enable;
	logic [3:0] lane_h, lanes, lane_out, lane_oe_n;
	logic [23:0] mem_addr;
	flsw_sr_t status_regs;
	int error_cnt = 0;
	int total_checks = 0;
	assign lanes = (lane_oe_n & lane_h) | (~lane_oe_n & lane_out);
	flsw_cmd_core #(.NV_WRITE_CYC(NVC)) uut (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
		.sck_pin(sck), .cs_n_pin(cs_n), .lane_in(lanes), .lane_out(lane_out), .lane_oe_n(lane_oe_n),
		.four_wire_command_mode(fw), .array_busy(array_busy), .mem_addr(mem_addr),
		.mem_rdata(mem_addr[7:0] ^ 8'h5a), .busy(busy), .write_latch_flag(write_latch_flag),
		.four_lane_enable(four_lane_enable), .status_regs(status_regs));
	flsw_host host (.clk(clk), .lanes(lanes), .sck(sck), .cs_n(cs_n), .lane_h(lane_h));
	task automatic summarize;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic op(input logic [31:0] d, input int n);
		logic [7:0] r;
		host.frame_on();
		for (int i = 0; i < n; i++) begin
			host.bits(d[31 - 8 * i -: 8], fw ? 4 : 1, r);
		end
		host.frame_off();
	endtask : op
	// read three bytes from 0000fe, crossing into the next 256 block
	task automatic rd(input logic [7:0] opc, input int dum, input int w, input logic ok);
		logic [7:0] r;
		logic [3:0] o;
		logic [31:0] d;
		d = {opc, 24'h0000fe};
		host.frame_on();
		for (int i = 0; i < 4; i++) begin
			host.bits(d[31 - 8 * i -: 8], fw ? 4 : 1, r);
		end
		repeat (dum) host.cyc(4'h0, o);
		for (int i = 0; i < 3; i++) begin
			host.bits(8'h00, w, r);
			if (ok) begin
				chk("rdata", {16'h0, (8'hfe + i[7:0]) ^ 8'h5a}, {16'h0, r});
			end else begin
				chk("oe", 24'hf, {20'h0, lane_oe_n});
			end
		end
		host.frame_off();
	endtask : rd
	task automatic wt;
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(posedge clk);
		end
		// status store updates one clock after busy falls
		repeat (4) @(posedge clk);
	endtask : wt
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		logic [7:0] r;
		reset_n = 1'b0;
		soft_reset = 1'b0;
		fw = 1'b0;
		array_busy = 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("status", 24'h0, status_regs);
		op({OP_WREN, 24'h0}, 1);
		chk("latch", 24'h1, {23'h0, write_latch_flag});
		op({OP_WSR1, 16'hffff, 8'h0}, 3);
		host.frame_on();
		host.bits(OP_RSR1, 1, r);
		host.bits(8'h00, 1, r);
		host.frame_off();
		chk("polled sr1", 24'h03, {16'h0, r});
		wt();
		chk("status", 24'h007bfc, status_regs);
		chk("qe", 24'h1, {23'h0, four_lane_enable});
		chk("latch", 24'h0, {23'h0, write_latch_flag});
		op({OP_WREN, 24'h0}, 1);
		op({OP_WSR2, 24'h0}, 2);
		wt();
		chk("status", 24'h0038fc, status_regs);
		op({OP_WREN, 24'h0}, 1);
		op({OP_WRDI, 24'h0}, 1);
		chk("latch", 24'h0, {23'h0, write_latch_flag});
		op({OP_WSR3, 8'hff, 16'h0}, 2);
		chk("status", 24'h0038fc, status_regs);
		op({OP_VWREN, 24'h0}, 1);
		op({OP_WSR3, 8'he0, 16'h0}, 2);
		chk("status", 24'he038fc, status_regs);
		chk("busy latch", 24'h0, {22'h0, busy, write_latch_flag});
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		repeat (4) @(posedge clk);
		chk("status", 24'h0038fc, status_regs);
		op({OP_WREN, 24'h0}, 1);
		op({OP_WSR1, 24'h0}, 2);
		wt();
		chk("status", 24'h003800, status_regs);
		host.frame_on();
		host.bits(OP_RSR2, 1, r);
		host.bits(8'h00, 1, r);
		host.frame_off();
		chk("sr2", 24'h38, {16'h0, r});
		rd(OP_READ, 0, 1, 1'b1);
		rd(OP_FAST, 8, 1, 1'b1);
		rd(OP_DUAL, 8, 2, 1'b1);
		array_busy <= 1'b1;
		rd(OP_READ, 0, 1, 1'b0);
		array_busy <= 1'b0;
		fw <= 1'b1;
		op({OP_WREN, 24'h0}, 1);
		op({OP_WSR2, 8'h7b, 16'h0}, 2);
		wt();
		chk("status", 24'h007900, status_regs);
		chk("qe", 24'h0, {23'h0, four_lane_enable});
		rd(OP_READ, 0, 1, 1'b0);
		rd(OP_DUAL, 8, 2, 1'b0);
		rd(OP_FAST, 8, 4, 1'b1);
		op({OP_SETP, 24'h0}, 2);
		rd(OP_FAST, 4, 4, 1'b1);
		op({OP_SETP, 8'h10, 16'h0}, 2);
		rd(OP_FAST, 6, 4, 1'b1);
		summarize();
	end
endmodule : flsw_cmd_core_bench
bind flsw_cmd_core flsw_cmd_core_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) props (.clk(clk), .reset_n(reset_n),
	.soft_reset(soft_reset), .cs_n_pin(cs_n_pin), .lane_oe_n(lane_oe_n),
	.four_wire_command_mode(four_wire_command_mode), .array_busy(array_busy), .mem_addr(mem_addr),
	.busy(busy), .write_latch_flag(write_latch_flag), .four_lane_enable(four_lane_enable),
	.status_regs(status_regs));
`default_nettype wire
